// >>> include/ppo_cfg.svh
`ifndef PPO_CFG_SVH
`define PPO_CFG_SVH

// timing
`define PPO_CLK_NS 100
`define PPO_MS_NS 1000000

// register indices; byte address is four times the index
`define PPO_IDX_MIN_WIDTH 14'h30EA
`define PPO_IDX_DBL_WINDOW 14'h30EB
`define PPO_IDX_LOCKOUT 14'h30E1
`define PPO_IDX_CTRL 14'h3100
`define PPO_IDX_OC_STAT 14'h3101
`define PPO_IDX_IRQ_MASK 14'h3102
`define PPO_IDX_PIN_STAT 14'h3103

// field position and min width limit
`define PPO_CTRL_GANGED_BIT 8
`define PPO_MIN_WIDTH_MAX 4'h5

// reset values
`define PPO_MIN_WIDTH_RST 4'h1
`define PPO_DBL_WINDOW_RST 8'h14
`define PPO_LOCKOUT_RST 8'h0A

`endif

// >>> include/ppo_pkg.sv
package ppo_pkg;

  typedef enum logic [2:0] {
    PPO_OFF = 3'b001,
    PPO_LOCK = 3'b010,
    PPO_RUN = 3'b100
  } ppo_det_state_t;

  typedef enum logic [2:0] {
    PPO_R_NONE,
    PPO_R_MIN_WIDTH,
    PPO_R_DBL_WINDOW,
    PPO_R_LOCKOUT,
    PPO_R_CTRL,
    PPO_R_OC_STAT,
    PPO_R_IRQ_MASK,
    PPO_R_PIN_STAT
  } ppo_reg_sel_t;

endpackage : ppo_pkg

// >>> include/ppo_det_if.sv
interface ppo_det_if;
  logic tick;
  logic pin_raw;
  logic powered;
  logic [3:0] min_width;
  logic [7:0] dbl_window;
  logic [7:0] lockout;
  logic oc_det;
  logic pin_level;

  modport ctl (output tick, output pin_raw, output powered, output min_width,
    output dbl_window, output lockout, input oc_det, input pin_level);
  modport det (input tick, input pin_raw, input powered, input min_width,
    input dbl_window, input lockout, output oc_det, output pin_level);
endinterface : ppo_det_if

// >>> rtl/ppo_port_det.sv
`include "ppo_cfg.svh"

module ppo_port_det (
  input wire logic pclk,
  input wire logic presetn,
  ppo_det_if.det dif
);
  import ppo_pkg::*;

  logic sync1_q;
  logic sync2_q;
  ppo_det_state_t state_q;
  logic [7:0] lock_cnt_q;
  logic [3:0] low_cnt_q;
  logic prev_low_q;
  logic [7:0] win_q;
  logic det_q;
  logic low;
  logic group_start;
  logic single_hit;
  logic [3:0] eff_width;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser ahead of any counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= dif.pin_raw;
      sync2_q <= sync1_q;
    end
  end

  assign dif.pin_level = sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // power-on lockout: pin ignored until the lockout count runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PPO_OFF;
      lock_cnt_q <= 8'h00;
    end else if (!dif.powered) begin
      state_q <= PPO_OFF;
    end else begin
      unique case (state_q)
        PPO_OFF: begin
          lock_cnt_q <= dif.lockout;
          state_q <= (dif.lockout == 8'h00) ? PPO_RUN : PPO_LOCK;
        end
        PPO_LOCK: begin
          if (dif.tick) begin
            lock_cnt_q <= lock_cnt_q - 8'h01;
            if (lock_cnt_q <= 8'h01) begin
              state_q <= PPO_RUN;
            end
          end
        end
        PPO_RUN: begin
          state_q <= PPO_RUN;
        end
        default: state_q <= PPO_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single long pulse and double short pulse detection on the ms tick
  // a code of zero still needs one low sample; codes above five act as five
  assign eff_width = (dif.min_width == 4'h0) ? 4'h1 :
    (dif.min_width > `PPO_MIN_WIDTH_MAX) ? `PPO_MIN_WIDTH_MAX : dif.min_width;
  assign low = !sync2_q;
  assign group_start = low && !prev_low_q;
  assign single_hit = low && ((low_cnt_q + 4'h1) >= eff_width);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= 4'h0;
      prev_low_q <= 1'b0;
      win_q <= 8'h00;
      det_q <= 1'b0;
    end else if (state_q != PPO_RUN || !dif.powered) begin
      low_cnt_q <= 4'h0;
      prev_low_q <= 1'b0;
      win_q <= 8'h00;
      det_q <= 1'b0;
    end else if (dif.tick) begin
      low_cnt_q <= !low ? 4'h0 : (low_cnt_q == 4'hF) ? low_cnt_q : low_cnt_q + 4'h1;
      prev_low_q <= low;
      if (group_start && win_q != 8'h00) begin
        win_q <= 8'h00;
        det_q <= 1'b1;
      end else begin
        if (group_start) begin
          win_q <= dif.dbl_window;
        end else if (win_q != 8'h00) begin
          win_q <= win_q - 8'h01;
        end
        det_q <= single_hit;
      end
    end else begin
      det_q <= 1'b0;
    end
  end

  assign dif.oc_det = det_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_lock_quiet;
    @(posedge pclk) disable iff (!presetn)
    (state_q == PPO_LOCK) |=> !det_q;
  endproperty
  a_lock_quiet: assert property (p_lock_quiet) else $error("detect during lockout");

  property p_off_when_unpowered;
    @(posedge pclk) disable iff (!presetn)
    !dif.powered |=> (state_q == PPO_OFF) && !det_q;
  endproperty
  a_off_when_unpowered: assert property (p_off_when_unpowered)
    else $error("detector active while unpowered");

  property p_det_from_low;
    @(posedge pclk) disable iff (!presetn)
    det_q |-> $past(dif.tick) && !$past(sync2_q);
  endproperty
  a_det_from_low: assert property (p_det_from_low)
    else $error("detect without low sample");

  property p_sync_depth;
    @(posedge pclk) disable iff (!presetn)
    $fell(dif.pin_raw) |-> ##2 !sync2_q;
  endproperty
  a_sync_depth: assert property (p_sync_depth) else $error("synchroniser depth wrong");

endmodule : ppo_port_det

// >>> rtl/ppo_top.sv
// Chosen here: the APB slave port.
`include "ppo_cfg.svh"

module ppo_top #(
  parameter int unsigned NUM_PORTS = 6,
  parameter int unsigned TICK_CYCLES = `PPO_MS_NS / `PPO_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_PORTS-1:0] port_power_sense_pin_level,
  output logic [NUM_PORTS-1:0] port_power_sense_pin_data,
  output logic [NUM_PORTS-1:0] port_power_sense_pin_en,
  output logic [NUM_PORTS-1:0] port_pullup_en,
  input wire logic shared_power_sense_pin_level,
  output logic shared_power_sense_pin_data,
  output logic shared_power_sense_pin_en,
  output logic shared_pullup_en,
  output logic irq
);
  import ppo_pkg::*;

  logic [3:0] min_width_q;
  logic [7:0] dbl_window_q;
  logic [7:0] lockout_q;
  logic ganged_q;
  logic [NUM_PORTS-1:0] pwr_q;
  logic [NUM_PORTS-1:0] oc_stat_q;
  logic [NUM_PORTS-1:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic [23:0] tick_cnt_q;
  logic tick_q;
  logic [NUM_PORTS-1:0] oc_event;
  logic [NUM_PORTS-1:0] det_hit;
  logic [NUM_PORTS-1:0] pin_level;
  logic [NUM_PORTS-1:0] port_on;
  logic wr_en;
  logic setup;
  ppo_reg_sel_t wr_sel;
  ppo_reg_sel_t rd_sel;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // register decode, shared by read and write paths
  function automatic ppo_reg_sel_t reg_decode(input logic [15:0] addr);
    ppo_reg_sel_t sel;
    sel = PPO_R_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[15:2])
        `PPO_IDX_MIN_WIDTH: sel = PPO_R_MIN_WIDTH;
        `PPO_IDX_DBL_WINDOW: sel = PPO_R_DBL_WINDOW;
        `PPO_IDX_LOCKOUT: sel = PPO_R_LOCKOUT;
        `PPO_IDX_CTRL: sel = PPO_R_CTRL;
        `PPO_IDX_OC_STAT: sel = PPO_R_OC_STAT;
        `PPO_IDX_IRQ_MASK: sel = PPO_R_IRQ_MASK;
        `PPO_IDX_PIN_STAT: sel = PPO_R_PIN_STAT;
        default: sel = PPO_R_NONE;
      endcase
    end
    return sel;
  endfunction : reg_decode

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero-wait access phase, read data captured in setup
  assign setup = psel && !penable;
  assign pready = psel && penable;
  assign pslverr = pready && err_q;
  assign prdata = rdata_q;
  assign wr_en = psel && penable && pwrite && !err_q;
  assign wr_sel = reg_decode(paddr);
  assign rd_sel = reg_decode(paddr);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_sel)
      PPO_R_MIN_WIDTH: rd_mux[3:0] = min_width_q;
      PPO_R_DBL_WINDOW: rd_mux[7:0] = dbl_window_q;
      PPO_R_LOCKOUT: rd_mux[7:0] = lockout_q;
      PPO_R_CTRL: begin
        rd_mux[NUM_PORTS-1:0] = pwr_q;
        rd_mux[`PPO_CTRL_GANGED_BIT] = ganged_q;
      end
      PPO_R_OC_STAT: rd_mux[NUM_PORTS-1:0] = oc_stat_q;
      PPO_R_IRQ_MASK: rd_mux[NUM_PORTS-1:0] = irq_mask_q;
      PPO_R_PIN_STAT: begin
        rd_mux[NUM_PORTS-1:0] = pin_level;
        rd_mux[`PPO_CTRL_GANGED_BIT] = pin_level[0];
      end
      PPO_R_NONE: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q <= (rd_sel == PPO_R_NONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing registers; software must not write zero to window or lockout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_width_q <= `PPO_MIN_WIDTH_RST;
      dbl_window_q <= `PPO_DBL_WINDOW_RST;
      lockout_q <= `PPO_LOCKOUT_RST;
    end else if (wr_en) begin
      if (wr_sel == PPO_R_MIN_WIDTH) begin
        min_width_q <= pwdata[3:0];
      end
      if (wr_sel == PPO_R_DBL_WINDOW) begin
        dbl_window_q <= pwdata[7:0];
      end
      if (wr_sel == PPO_R_LOCKOUT) begin
        lockout_q <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control: mode and per-port power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ganged_q <= 1'b0;
      pwr_q <= '0;
    end else if (wr_en && wr_sel == PPO_R_CTRL) begin
      ganged_q <= pwdata[`PPO_CTRL_GANGED_BIT];
      pwr_q <= pwdata[NUM_PORTS-1:0];
    end
  end

  // in ganged mode the power bit of port 0 switches every port
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      port_on[i] = ganged_q ? pwr_q[0] : pwr_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 1 ms sampling tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers: off drives low with pull-up off, on releases with pull-up
  // unused pins of the other mode sit driven low so they never float
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      port_power_sense_pin_en[i] = ganged_q || !pwr_q[i];
      port_pullup_en[i] = !ganged_q && pwr_q[i];
    end
  end
  assign port_power_sense_pin_data = '0;
  assign shared_power_sense_pin_data = 1'b0;
  assign shared_power_sense_pin_en = !(ganged_q && pwr_q[0]);
  assign shared_pullup_en = ganged_q && pwr_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // one detector per port; channel 0 watches the shared pin when ganged
  generate
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
      ppo_det_if dif ();
      if (g == 0) begin : g_src
        assign dif.pin_raw = ganged_q ? shared_power_sense_pin_level
                                      : port_power_sense_pin_level[0];
        assign dif.powered = pwr_q[0];
      end else begin : g_src
        assign dif.pin_raw = port_power_sense_pin_level[g];
        assign dif.powered = !ganged_q && pwr_q[g];
      end
      assign dif.tick = tick_q;
      assign dif.min_width = min_width_q;
      assign dif.dbl_window = dbl_window_q;
      assign dif.lockout = lockout_q;
      assign det_hit[g] = dif.oc_det;
      assign pin_level[g] = dif.pin_level;
      ppo_port_det u_det (
        .pclk(pclk),
        .presetn(presetn),
        .dif(dif)
      );
    end
  endgenerate

  assign oc_event = ganged_q ? {NUM_PORTS{det_hit[0]}} : det_hit;

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: set wins over write-one-clear and over power off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_stat_q <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (oc_event[i]) begin
          oc_stat_q[i] <= 1'b1;
        end else if (!port_on[i] || (wr_en && wr_sel == PPO_R_OC_STAT && pwdata[i])) begin
          oc_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_en && wr_sel == PPO_R_IRQ_MASK) begin
      irq_mask_q <= pwdata[NUM_PORTS-1:0];
    end
  end

  assign irq = |(oc_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  property p_gang_flags_all;
    @(posedge pclk) disable iff (!presetn)
    (ganged_q && det_hit[0]) |=> (oc_stat_q == {NUM_PORTS{1'b1}});
  endproperty
  a_gang_flags_all: assert property (p_gang_flags_all)
    else $error("ganged flag not on all ports");

  property p_pin_off_drive;
    @(posedge pclk) disable iff (!presetn)
    !ganged_q |-> (port_power_sense_pin_en == ~pwr_q) && (port_pullup_en == pwr_q);
  endproperty
  a_pin_off_drive: assert property (p_pin_off_drive) else $error("port pin drive wrong");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (oc_event[0] && wr_en && wr_sel == PPO_R_OC_STAT && pwdata[0]) |=> oc_stat_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

  property p_flag_held;
    @(posedge pclk) disable iff (!presetn)
    (oc_stat_q[0] && port_on[0] && !(wr_en && wr_sel == PPO_R_OC_STAT)) |=> oc_stat_q[0];
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("flag dropped without clear");

  property p_tick_spacing;
    @(posedge pclk) disable iff (!presetn)
    tick_q |=> !tick_q;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("tick wider than one cycle");

  property p_reset_mode;
    @(posedge pclk)
    $rose(presetn) |-> !ganged_q && !shared_pullup_en;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("not individual after reset");

  property p_shared_drive;
    @(posedge pclk) disable iff (!presetn)
    ganged_q |-> (port_power_sense_pin_en == {NUM_PORTS{1'b1}}) && (port_pullup_en == '0)
      && (shared_pullup_en == pwr_q[0]) && (shared_power_sense_pin_en == !pwr_q[0]);
  endproperty
  a_shared_drive: assert property (p_shared_drive) else $error("ganged drive wrong");

  property p_shared_idle;
    @(posedge pclk) disable iff (!presetn)
    !ganged_q |-> shared_power_sense_pin_en && !shared_pullup_en;
  endproperty
  a_shared_idle: assert property (p_shared_idle) else $error("shared pin not held low");

  property p_gang_hold;
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && wr_sel == PPO_R_CTRL) |=> $stable(ganged_q);
  endproperty
  a_gang_hold: assert property (p_gang_hold) else $error("mode changed without write");

  property p_gang_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && wr_sel == PPO_R_CTRL) |=> (ganged_q == $past(pwdata[`PPO_CTRL_GANGED_BIT]));
  endproperty
  a_gang_write: assert property (p_gang_write) else $error("mode write lost");

  property p_width_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && wr_sel == PPO_R_MIN_WIDTH) |=> (min_width_q == $past(pwdata[3:0]));
  endproperty
  a_width_write: assert property (p_width_write) else $error("width write lost");

  property p_window_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && wr_sel == PPO_R_DBL_WINDOW) |=> (dbl_window_q == $past(pwdata[7:0]));
  endproperty
  a_window_write: assert property (p_window_write) else $error("window write lost");

  property p_lockout_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && wr_sel == PPO_R_LOCKOUT) |=> (lockout_q == $past(pwdata[7:0]));
  endproperty
  a_lockout_write: assert property (p_lockout_write) else $error("lockout write lost");

  property p_w1c_clear;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && wr_sel == PPO_R_OC_STAT && pwdata[0] && !oc_event[0]) |=> !oc_stat_q[0];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared by write");

  property p_off_clear;
    @(posedge pclk) disable iff (!presetn)
    (!port_on[0] && !oc_event[0]) |=> !oc_stat_q[0];
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("flag kept after power off");

  property p_flag_from_event;
    @(posedge pclk) disable iff (!presetn)
    $rose(oc_stat_q[0]) |-> $past(oc_event[0]);
  endproperty
  a_flag_from_event: assert property (p_flag_from_event) else $error("stray flag");

endmodule : ppo_top

// >>> verif/ppo_switch_model.sv
module ppo_switch_model #(
  parameter int unsigned N = 6
) (
  input wire logic pclk,
  input wire logic [N-1:0] en,
  input wire logic [N-1:0] pu,
  input wire logic [N-1:0] fault,
  output logic [N-1:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic alt_q;
  // a floating pin with no pull-up must not show a stale level
  always_ff @(posedge pclk) begin
    alt_q <= (alt_q === 1'b1) ? 1'b0 : 1'b1;
  end
  for (genvar i = 0; i < N; i++) begin : g_pin
    // switch fault output is open drain on the same wire as power enable
    assign level[i] = en[i] ? 1'b0 : (fault[i] ? 1'b0 : (pu[i] ? 1'b1 : alt_q));
  end
endmodule : ppo_switch_model

// >>> verif/test_ppo_top.sv
`include "ppo_cfg.svh"
module test_ppo_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic wr; logic err; logic [31:0] data;} ppo_exp_t;
  localparam logic [13:0] I_MW = `PPO_IDX_MIN_WIDTH;
  localparam logic [13:0] I_DW = `PPO_IDX_DBL_WINDOW;
  localparam logic [13:0] I_LO = `PPO_IDX_LOCKOUT;
  localparam logic [13:0] I_CT = `PPO_IDX_CTRL;
  localparam logic [13:0] I_OC = `PPO_IDX_OC_STAT;
  localparam logic [13:0] I_MK = `PPO_IDX_IRQ_MASK;
  localparam logic [13:0] I_PS = `PPO_IDX_PIN_STAT;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [5:0] p_lvl, p_dat, p_en, p_pu, p_flt;
  logic s_lvl, s_dat, s_en, s_pu, s_flt;
  int fail_count, n_compared;
  ppo_exp_t exp_q[$];
  ppo_exp_t e;

  ppo_top #(.NUM_PORTS(6), .TICK_CYCLES(10)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .port_power_sense_pin_level(p_lvl), .port_power_sense_pin_data(p_dat),
    .port_power_sense_pin_en(p_en), .port_pullup_en(p_pu),
    .shared_power_sense_pin_level(s_lvl), .shared_power_sense_pin_data(s_dat),
    .shared_power_sense_pin_en(s_en), .shared_pullup_en(s_pu), .irq(irq));
  ppo_switch_model #(.N(6)) port_sw_u (.pclk(pclk), .en(p_en), .pu(p_pu),
    .fault(p_flt), .level(p_lvl));
  // one switch on the shared pin stands for all ganged ports
  ppo_switch_model #(.N(1)) gang_sw_u (.pclk(pclk), .en(s_en), .pu(s_pu),
    .fault(s_flt), .level(s_lvl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic expire();
    fail_count++;
    $display("ERROR %0t: wait expired", $time);
    give_verdict();
  endtask : expire

  // d is write data, or the expected read data
  task automatic xfer(input logic w, input logic [13:0] idx, input logic [31:0] d,
      input logic err = 1'b0);
    int n;
    @(posedge pclk);
    exp_q.push_back('{w, err, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) expire();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic hold(input logic [6:0] m, input int c);
    @(posedge pclk);
    {s_flt, p_flt} <= m;
    repeat (c) @(posedge pclk);
    {s_flt, p_flt} <= 7'h00;
  endtask : hold

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        chk(32'(pslverr), 32'(e.err));
        if (!e.wr) chk(prdata, e.data);
      end
    end
  end

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    repeat (50000) @(posedge pclk);
    expire();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {p_flt, s_flt, presetn} = '0;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(44));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'({p_en, p_pu, s_en, s_pu}), 32'h3F02);
    chk(32'({irq, p_dat, s_dat}), 32'h0);
    xfer(1'b0, I_MW, 32'h1);
    xfer(1'b0, I_DW, `PPO_DBL_WINDOW_RST);
    xfer(1'b0, I_LO, `PPO_LOCKOUT_RST);
    xfer(1'b0, I_CT, 32'h0);
    xfer(1'b0, 14'h30EC, 32'h0, 1'b1);
    for (int c = 0; c < 6; c++) begin
      xfer(1'b1, I_MW, 32'hFFFFFFF0 | c);
      xfer(1'b0, I_MW, 32'(c));
    end
    repeat (3) begin
      v = $urandom_range(255, 1);
      xfer(1'b1, I_DW, v);
      xfer(1'b0, I_DW, v);
      xfer(1'b1, I_LO, v ^ 32'h1);
      xfer(1'b0, I_LO, v ^ 32'h1);
    end
    xfer(1'b1, I_DW, 32'h14);
    xfer(1'b1, I_LO, 32'h0A);
    xfer(1'b1, I_MW, 32'h3);
    xfer(1'b1, I_MK, 32'h3F);
    // port 0 powered: released with pull-up, others still held low
    xfer(1'b1, I_CT, 32'h1);
    @(negedge pclk);
    chk(32'({p_en, p_pu}), 32'hF81);
    // a fault wholly inside the lockout must leave no trace
    repeat (10) @(posedge pclk);
    hold(7'h01, 60);
    repeat (50) @(posedge pclk);
    xfer(1'b0, I_OC, 32'h0);
    xfer(1'b0, I_PS, 32'h101);
    hold(7'h01, 60);
    repeat (20) @(posedge pclk);
    xfer(1'b0, I_OC, 32'h1);
    chk(32'(irq), 32'h1);
    xfer(1'b1, I_MK, 32'h0);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    xfer(1'b0, I_OC, 32'h1);
    xfer(1'b1, I_OC, 32'h1);
    xfer(1'b0, I_OC, 32'h0);
    xfer(1'b1, I_MK, 32'h3F);
    // two short pulses further apart than the window, then closer
    repeat (300) @(posedge pclk);
    xfer(1'b1, I_DW, 32'h2);
    hold(7'h01, 15);
    repeat (50) @(posedge pclk);
    hold(7'h01, 15);
    repeat (20) @(posedge pclk);
    xfer(1'b0, I_OC, 32'h0);
    repeat (300) @(posedge pclk);
    xfer(1'b1, I_DW, 32'h14);
    hold(7'h01, 15);
    repeat (50) @(posedge pclk);
    hold(7'h01, 15);
    repeat (20) @(posedge pclk);
    xfer(1'b0, I_OC, 32'h1);
    xfer(1'b1, I_CT, 32'h0);
    // the flag clears one cycle after power goes off
    repeat (2) @(negedge pclk);
    chk(32'({p_en, p_pu, irq}), 32'h1F80);
    xfer(1'b0, I_OC, 32'h0);
    // ganged: shared pin powers and senses, a fault flags every port
    xfer(1'b1, I_CT, 32'h101);
    @(negedge pclk);
    chk(32'({p_en, p_pu, s_en, s_pu}), 32'h3F01);
    repeat (150) @(posedge pclk);
    hold(7'h40, 60);
    repeat (20) @(posedge pclk);
    xfer(1'b0, I_OC, 32'h3F);
    give_verdict();
  end
endmodule : test_ppo_top
